// ---- rtl/sep_regs.svh ----
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH
// array shape
`define SEP_WORDS 128
`define SEP_DW 16
`define SEP_AW 7
`define SEP_ABYTE 8
`define SEP_PAGE_N 4
`define SEP_PAGE 3'h4
`define SEP_ONE 3'h1
`define SEP_ERASED 16'hFFFF
// protect register
`define SEP_PRBITS 9
`define SEP_PREG_RST 8'hFF
// instruction fields
`define SEP_OP_RD 2'h2
`define SEP_OP_WR 2'h1
`define SEP_OP_PW 2'h3
`define SEP_OP_SYS 2'h0
`define SEP_SUB_WA 2'h1
`define SEP_SUB_EN 2'h3
`define SEP_SUB_DS 2'h0
`define SEP_ADR_ALL1 8'hFF
`define SEP_ADR_ALL0 8'h00
// bit counters
`define SEP_CMD_LAST 4'h9
`define SEP_BIT_LAST 4'hF
// program_cycle_time
`define SEP_TW_MS 10
`define SEP_CLK_MHZ 125
`define SEP_KHZ_PER_MHZ 1000
`endif

// ---- rtl/sep_pkg.sv ----
`default_nettype none
`include "sep_regs.svh"
package sep_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_RDAT, ST_PRD, ST_DONE} sep_state_t;
	typedef enum logic [2:0] {PK_NONE, PK_WR, PK_PW, PK_WA, PK_PRW, PK_PRC, PK_OTP} sep_kind_t;
	typedef struct packed {
		logic cs;
		logic sclk;
		logic sdi;
		logic pre;
		logic wen;
	} sep_pins_t;
	typedef struct packed {
		sep_kind_t kind;
		logic [`SEP_ABYTE-1:0] adr;
		logic [2:0] cnt;
	} sep_job_t;
endpackage
`default_nettype wire

// ---- rtl/sep_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sep_regs.svh"
// Behaviour
// - array of 128 words of 16 bits
// - read loads address pointer first
// - pointer advances, stream continues while selected
// - pointer wraps from top to zero
// - single write programs one whole word
// - page write: up to four consecutive words
// - write-all fills every word with pattern
// - protect register sets protected boundary
// - writes refused if any address protected
// - lock bit freezes protect register until reset
// - programming self-timed, sclk not needed
// - target erased before programming
// - ready/busy on output when selected
// - first sampled one is start bit
// - two-bit opcode then eight-bit address
// - read: dummy zero then word MSB first
// - reset clears programming, writes disabled
module sep_top import sep_pkg::*; #(
	parameter int PROG_CYCLES = `SEP_TW_MS * `SEP_KHZ_PER_MHZ * `SEP_CLK_MHZ,
	parameter int FIFO_DEPTH = 2,
	parameter int FIFO_W = `SEP_DW
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// serial link inputs
	input wire logic cs_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic prot_en_i,
	input wire logic wr_en_i,
	// serial output, three-state
	output logic sdo_o,
	output logic sdo_oe_n_o
);
	localparam int TW = $clog2(PROG_CYCLES + 1);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [TW-1:0] TMR_INIT = TW'(PROG_CYCLES - 1);
	localparam logic [CW-1:0] FIFO_FULL = CW'(FIFO_DEPTH);

	// ****************************************
	// pin synchronisers
	// ****************************************
	sep_pins_t pin_m_ff, pin_s_ff;
	logic sclk_d_ff, cs_d_ff, rise, cs_fall;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pin_m_ff <= '0;
			pin_s_ff <= '0;
			sclk_d_ff <= 1'b0;
			cs_d_ff <= 1'b0;
		end else begin
			pin_m_ff <= {cs_i, sclk_i, sdi_i, prot_en_i, wr_en_i};
			pin_s_ff <= pin_m_ff;
			sclk_d_ff <= pin_s_ff.sclk;
			cs_d_ff <= pin_s_ff.cs;
		end
	end
	assign rise = pin_s_ff.sclk & ~sclk_d_ff;
	assign cs_fall = ~pin_s_ff.cs & cs_d_ff;

	// ****************************************
	// state
	// ****************************************
	logic [FIFO_W-1:0] mem [`SEP_WORDS];
	logic [`SEP_DW-1:0] page_ff [`SEP_PAGE_N], nxt_page [`SEP_PAGE_N];
	logic [FIFO_W-1:0] fq_ff [FIFO_DEPTH], nxt_fq [FIFO_DEPTH];
	sep_state_t st_ff, nxt_st;
	sep_job_t job_ff, nxt_job, prg_ff, nxt_prg, src;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [`SEP_DW-1:0] sr_ff, nxt_sr, sh_ff, nxt_sh;
	logic [`SEP_ABYTE-1:0] preg_ff, nxt_preg;
	logic [`SEP_AW-1:0] ptr_ff, nxt_ptr;
	logic [TW-1:0] tmr_ff, nxt_tmr;
	logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [CW-1:0] fc_ff, nxt_fc;
	logic wen_ff, nxt_wen, pren_ff, nxt_pren, flag_ff, nxt_flag, otp_ff, nxt_otp;
	logic busy_ff, nxt_busy, sdo_ff, nxt_sdo, oe_n_ff, nxt_oe_n;
	logic [`SEP_CMD_LAST+1-1:0] cmd_w;
	logic fifo_push, fifo_pop, wr_ok, pr_ok, start_ok, erase_go, prog_go, data_kind;
	logic [`SEP_WORDS-1:0] mem_sel;
	logic [`SEP_DW-1:0] mem_dat [`SEP_WORDS];

	// any page word at or above the boundary hits the protected area
	function automatic logic prot_hit(input logic [`SEP_AW-1:0] b, input logic [2:0] n);
		logic h;
		logic [`SEP_AW-1:0] a;
		h = 1'b0;
		for (int j = 0; j < `SEP_PAGE_N; j++) begin
			a = b + `SEP_AW'(j);
			if (3'(j) < n && a >= preg_ff[`SEP_AW-1:0]) h = 1'b1;
		end
		return h;
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_job = job_ff;
		nxt_prg = prg_ff;
		nxt_cnt = cnt_ff;
		nxt_sr = sr_ff;
		nxt_sh = sh_ff;
		nxt_preg = preg_ff;
		nxt_ptr = ptr_ff;
		nxt_tmr = tmr_ff;
		nxt_wp = wp_ff;
		nxt_rp = rp_ff;
		nxt_fc = fc_ff;
		nxt_wen = wen_ff;
		nxt_pren = pren_ff;
		nxt_flag = flag_ff;
		nxt_otp = otp_ff;
		nxt_busy = busy_ff;
		nxt_sdo = sdo_ff;
		nxt_page = page_ff;
		nxt_fq = fq_ff;
		cmd_w = {sr_ff[`SEP_CMD_LAST-1:0], pin_s_ff.sdi};
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		erase_go = 1'b0;
		prog_go = 1'b0;
		wr_ok = pin_s_ff.wen & wen_ff;
		pr_ok = wr_ok & pren_ff & ~otp_ff;
		data_kind = job_ff.kind == PK_WR || job_ff.kind == PK_PW || job_ff.kind == PK_WA;
		start_ok = 1'b0;
		nxt_oe_n = ~pin_s_ff.cs;

		// self-timed cycle runs on clk_i alone, sclk may stop
		if (busy_ff) begin
			if (tmr_ff == '0) begin
				nxt_busy = 1'b0;
				prog_go = 1'b1;
				if (!otp_ff) begin
					unique case (prg_ff.kind)
						PK_PRW: begin
							nxt_preg = prg_ff.adr;
							nxt_flag = 1'b0;
						end
						PK_PRC: begin
							nxt_preg = `SEP_PREG_RST;
							nxt_flag = 1'b1;
						end
						PK_OTP: nxt_otp = 1'b1;
						default: ;
					endcase
				end
			end else begin
				nxt_tmr = tmr_ff - 1'b1;
			end
		end

		if (!pin_s_ff.cs) begin
			nxt_st = ST_IDLE;
			nxt_cnt = '0;
			nxt_wp = '0;
			nxt_rp = '0;
			nxt_fc = '0;
			nxt_job.kind = PK_NONE;
			// programming starts when the instruction frame closes
			if (cs_fall && !busy_ff && job_ff.kind != PK_NONE) begin
				if (!data_kind)
					start_ok = 1'b1;
				else if (job_ff.kind == PK_WA)
					start_ok = flag_ff && job_ff.cnt != '0;
				else
					start_ok = job_ff.cnt != '0 && (flag_ff || !prot_hit(job_ff.adr[`SEP_AW-1:0], job_ff.cnt));
			end
			if (start_ok) begin
				nxt_busy = 1'b1;
				nxt_tmr = TMR_INIT;
				nxt_prg = job_ff;
				erase_go = data_kind;
			end
		end else begin
			if (st_ff == ST_IDLE)
				nxt_sdo = ~busy_ff;
			if (rise) begin
				unique case (st_ff)
					ST_IDLE: begin
						// start bits are ignored while programming
						if (!busy_ff && pin_s_ff.sdi) begin
							nxt_st = ST_CMD;
							nxt_cnt = '0;
						end
					end
					ST_CMD: begin
						nxt_sr = {sr_ff[`SEP_DW-2:0], pin_s_ff.sdi};
						nxt_cnt = cnt_ff + 1'b1;
						if (cnt_ff == `SEP_CMD_LAST) begin
							nxt_st = ST_DONE;
							nxt_cnt = '0;
							if (!pin_s_ff.pre) begin
								unique case (cmd_w[9:8])
									`SEP_OP_RD: begin
										nxt_ptr = cmd_w[`SEP_AW-1:0];
										nxt_sdo = 1'b0;
										nxt_st = ST_RDAT;
									end
									`SEP_OP_WR: if (wr_ok) begin
										nxt_st = ST_DATA;
										nxt_job = '{PK_WR, cmd_w[7:0], 3'h0};
									end
									`SEP_OP_PW: if (wr_ok) begin
										nxt_st = ST_DATA;
										nxt_job = '{PK_PW, cmd_w[7:0], 3'h0};
									end
									`SEP_OP_SYS: begin
										if (cmd_w[7:6] == `SEP_SUB_WA && wr_ok) begin
											nxt_st = ST_DATA;
											nxt_job = '{PK_WA, cmd_w[7:0], 3'h0};
										end else if (cmd_w[7:6] == `SEP_SUB_EN && pin_s_ff.wen) begin
											nxt_wen = 1'b1;
										end else if (cmd_w[7:6] == `SEP_SUB_DS) begin
											nxt_wen = 1'b0;
											nxt_pren = 1'b0;
										end
									end
								endcase
							end else begin
								unique case (cmd_w[9:8])
									`SEP_OP_RD: begin
										nxt_sh = {preg_ff, flag_ff, {(`SEP_DW - `SEP_PRBITS){1'b0}}};
										nxt_sdo = 1'b0;
										nxt_st = ST_PRD;
									end
									`SEP_OP_WR: if (pr_ok)
										nxt_job = '{PK_PRW, cmd_w[7:0], 3'h0};
									`SEP_OP_PW: if (pr_ok && cmd_w[7:0] == `SEP_ADR_ALL1)
										nxt_job = '{PK_PRC, cmd_w[7:0], 3'h0};
									`SEP_OP_SYS: begin
										if (cmd_w[7:6] == `SEP_SUB_EN && wr_ok)
											nxt_pren = 1'b1;
										else if (cmd_w[7:0] == `SEP_ADR_ALL0 && pr_ok)
											nxt_job = '{PK_OTP, cmd_w[7:0], 3'h0};
									end
								endcase
							end
						end
					end
					ST_DATA: begin
						nxt_sr = {sr_ff[`SEP_DW-2:0], pin_s_ff.sdi};
						nxt_cnt = cnt_ff + 1'b1;
						// surplus words beyond the page are dropped
						if (cnt_ff == `SEP_BIT_LAST &&
							job_ff.cnt < ((job_ff.kind == PK_PW) ? `SEP_PAGE : `SEP_ONE)) begin
							nxt_page[job_ff.cnt[1:0]] = nxt_sr;
							nxt_job.cnt = job_ff.cnt + 1'b1;
						end
					end
					ST_RDAT: begin
						nxt_cnt = cnt_ff + 1'b1;
						if (cnt_ff == '0) begin
							nxt_sdo = fq_ff[rp_ff][FIFO_W-1];
							nxt_sh = {fq_ff[rp_ff][FIFO_W-2:0], 1'b0};
							fifo_pop = fc_ff != '0;
						end else begin
							nxt_sdo = sh_ff[`SEP_DW-1];
							nxt_sh = {sh_ff[`SEP_DW-2:0], 1'b0};
						end
					end
					ST_PRD: begin
						nxt_sdo = sh_ff[`SEP_DW-1];
						nxt_sh = {sh_ff[`SEP_DW-2:0], 1'b0};
					end
					ST_DONE: ;
				endcase
			end
			// prefetch keeps the buffer ahead of the shifter
			if (st_ff == ST_RDAT && fc_ff != FIFO_FULL) begin
				fifo_push = 1'b1;
				nxt_fq[wp_ff] = mem[ptr_ff];
				nxt_ptr = ptr_ff + 1'b1;
				nxt_wp = (wp_ff == PW'(FIFO_DEPTH - 1)) ? '0 : wp_ff + 1'b1;
			end
			if (fifo_pop)
				nxt_rp = (rp_ff == PW'(FIFO_DEPTH - 1)) ? '0 : rp_ff + 1'b1;
			nxt_fc = fc_ff + CW'(fifo_push) - CW'(fifo_pop);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_ff <= ST_IDLE;
			job_ff <= '0;
			prg_ff <= '0;
			cnt_ff <= '0;
			sr_ff <= '0;
			sh_ff <= '0;
			preg_ff <= `SEP_PREG_RST;
			ptr_ff <= '0;
			tmr_ff <= '0;
			wp_ff <= '0;
			rp_ff <= '0;
			fc_ff <= '0;
			wen_ff <= 1'b0;
			pren_ff <= 1'b0;
			flag_ff <= 1'b1;
			otp_ff <= 1'b0;
			busy_ff <= 1'b0;
			sdo_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			page_ff <= '{default: '0};
			fq_ff <= '{default: '0};
		end else begin
			st_ff <= nxt_st;
			job_ff <= nxt_job;
			prg_ff <= nxt_prg;
			cnt_ff <= nxt_cnt;
			sr_ff <= nxt_sr;
			sh_ff <= nxt_sh;
			preg_ff <= nxt_preg;
			ptr_ff <= nxt_ptr;
			tmr_ff <= nxt_tmr;
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			fc_ff <= nxt_fc;
			wen_ff <= nxt_wen;
			pren_ff <= nxt_pren;
			flag_ff <= nxt_flag;
			otp_ff <= nxt_otp;
			busy_ff <= nxt_busy;
			sdo_ff <= nxt_sdo;
			oe_n_ff <= nxt_oe_n;
			page_ff <= nxt_page;
			fq_ff <= nxt_fq;
		end
	end
	assign sdo_o = sdo_ff;
	assign sdo_oe_n_o = oe_n_ff;

	// ****************************************
	// array write: erase at start, program at end
	// ****************************************
	always_comb begin
		logic [`SEP_AW-1:0] off;
		off = '0;
		src = busy_ff ? prg_ff : job_ff;
		for (int i = 0; i < `SEP_WORDS; i++) begin
			off = `SEP_AW'(i) - src.adr[`SEP_AW-1:0];
			mem_sel[i] = (src.kind == PK_WA) ||
				((src.kind == PK_WR || src.kind == PK_PW) && off < `SEP_AW'(src.cnt));
			mem_dat[i] = (src.kind == PK_WA) ? page_ff[0] : page_ff[off[1:0]];
		end
	end

	// no reset: array contents are nonvolatile
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < `SEP_WORDS; i++) begin
			if (mem_sel[i] && erase_go)
				mem[i] <= `SEP_ERASED;
			else if (mem_sel[i] && prog_go)
				mem[i] <= mem_dat[i];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_rd_cmd;
		rise && pin_s_ff.cs && st_ff == ST_CMD && cnt_ff == `SEP_CMD_LAST &&
			!pin_s_ff.pre && cmd_w[9:8] == `SEP_OP_RD;
	endsequence
	sequence s_commit;
		busy_ff && tmr_ff == '0;
	endsequence

	rd_ptr_load_a: assert property (s_rd_cmd |=> ptr_ff == $past(cmd_w[6:0]) && st_ff == ST_RDAT)
		else $error("read address not loaded");
	rd_dummy_a: assert property (s_rd_cmd |=> !sdo_o ##1 (st_ff == ST_RDAT || !pin_s_ff.cs))
		else $error("dummy bit not zero");
	ptr_wrap_a: assert property (fifo_push && ptr_ff == '1 |=> ptr_ff == '0)
		else $error("pointer did not wrap");
	fifo_bound_a: assert property (fc_ff <= FIFO_FULL && !(fifo_push && fc_ff == FIFO_FULL))
		else $error("read buffer overflow");
	prog_len_a: assert property ($rose(busy_ff) |-> tmr_ff == TMR_INIT)
		else $error("program time wrong");
	busy_hold_a: assert property (busy_ff && tmr_ff != '0 |=> busy_ff)
		else $error("busy ended early");
	erase_first_a: assert property (erase_go |=> mem[$past(job_ff.adr[6:0])] == `SEP_ERASED)
		else $error("target not erased");
	word_prog_a: assert property (s_commit ##0 prg_ff.kind == PK_WR |=>
		mem[$past(prg_ff.adr[6:0])] == $past(page_ff[0]))
		else $error("word not programmed");
	page_last_a: assert property (s_commit ##0 prg_ff.kind == PK_PW && prg_ff.cnt == `SEP_PAGE |=>
		mem[$past(prg_ff.adr[6:0]) + 7'h3] == $past(page_ff[3]))
		else $error("page word four missing");
	wrall_fill_a: assert property (s_commit ##0 prg_ff.kind == PK_WA |=>
		mem[0] == $past(page_ff[0]) && mem[`SEP_WORDS-1] == $past(page_ff[0]))
		else $error("write all incomplete");
	preg_set_a: assert property (s_commit ##0 prg_ff.kind == PK_PRW && !otp_ff |=>
		preg_ff == $past(prg_ff.adr) && !flag_ff)
		else $error("protect register not set");
	prot_refuse_a: assert property (cs_fall && !busy_ff && job_ff.kind == PK_WR && !flag_ff &&
		job_ff.adr[6:0] >= preg_ff[6:0] |=> !busy_ff)
		else $error("protected write started");
	otp_lock_a: assert property (otp_ff |=> $stable(preg_ff) && $stable(flag_ff) && otp_ff)
		else $error("locked register changed");
	busy_show_a: assert property (pin_s_ff.cs && st_ff == ST_IDLE && busy_ff |=> !sdo_o && !sdo_oe_n_o)
		else $error("busy not shown");
	start_bit_a: assert property (rise && pin_s_ff.cs && st_ff == ST_IDLE && !busy_ff && pin_s_ff.sdi |=>
		st_ff == ST_CMD)
		else $error("start bit missed");
	cmd_len_a: assert property (rise && pin_s_ff.cs && st_ff == ST_CMD && cnt_ff == `SEP_CMD_LAST |=>
		st_ff != ST_CMD)
		else $error("command length wrong");
	rst_state_a: assert property (disable iff (1'b0) !nrst_i |=> !wen_ff && !busy_ff && st_ff == ST_IDLE)
		else $error("reset state wrong");
	oe_release_a: assert property (!pin_s_ff.cs |=> sdo_oe_n_o)
		else $error("output driven while deselected");
endmodule // sep_top
`default_nettype wire

// ---- tb/sep_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************
// host end of the serial link
// ****************
module sep_host import sep_pkg::*; (
	// clock
	input wire logic clk_i,
	// device output, three-state
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i,
	// link pins
	output var sep_pins_t pins_o
);
	// half link period, 80 ns link clock
	localparam int HALF = 5;
	logic q = 1'b0;
	initial pins_o = '0;
	// sdi moves only while sclk is low; sdo read just before the fall
	task automatic bit_x(input logic b, output logic r);
		pins_o.sdi <= b;
		repeat (HALF) @(posedge clk_i);
		pins_o.sclk <= 1'b1;
		repeat (HALF) @(posedge clk_i);
		// undriven line: no pull, so show the opposite of the last level
		r = sdo_oe_n_i ? ~q : sdo_i;
		q = r;
		pins_o.sclk <= 1'b0;
	endtask
	task automatic select(input logic pre, input logic w);
		pins_o.pre <= pre;
		pins_o.wen <= w;
		pins_o.cs <= 1'b1;
		repeat (2 * HALF) @(posedge clk_i);
	endtask
	// sclk stands low between frames
	task automatic release_cs();
		pins_o.cs <= 1'b0;
		pins_o.sdi <= ~pins_o.sdi;
		repeat (32) @(posedge clk_i);
	endtask
	// start bit, op code, address; r is the bit seen after the last address rise
	task automatic cmd(input logic pre, input logic w, input logic [1:0] op, input logic [7:0] adr, output logic r);
		logic [10:0] v;
		v = {1'b1, op, adr};
		select(pre, w);
		for (int i = 10; i >= 0; i--) bit_x(v[i], r);
	endtask
	// one word each way, cs kept high so a read keeps streaming
	task automatic shift16(input logic [15:0] d, output logic [15:0] r);
		logic b;
		for (int i = 15; i >= 0; i--) begin
			bit_x(d[i], b);
			r[i] = b;
		end
	endtask
endmodule // sep_host
`default_nettype wire

// ---- tb/sep_top_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sep_regs.svh"
module sep_top_bench import sep_pkg::*; ;
	// short program cycle keeps the run brief
	localparam int PROG = 200;
	localparam int CEIL = 40000;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sdo_o;
	logic sdo_oe_n_o;
	sep_pins_t pins;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	logic d;
	logic [15:0] w;
	always #4 clk_i = ~clk_i;
	sep_top #(.PROG_CYCLES(PROG), .FIFO_DEPTH(2), .FIFO_W(16)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.cs_i(pins.cs), .sclk_i(pins.sclk), .sdi_i(pins.sdi), .prot_en_i(pins.pre), .wr_en_i(pins.wen),
		.sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o));
	sep_host host (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o), .pins_o(pins));
	// ****************
	// checking and closing
	// ****************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == CEIL) begin
			errors = errors + 1;
			end_of_test();
		end
	end
	// ****************
	// shared frames
	// ****************
	task automatic sys(input logic pre, input logic [7:0] adr);
		host.cmd(pre, 1'b1, `SEP_OP_SYS, adr, d);
		host.release_cs();
	endtask
	task automatic write1(input logic [7:0] adr, input logic [15:0] v);
		host.cmd(1'b0, 1'b1, `SEP_OP_WR, adr, d);
		host.shift16(v, w);
		host.release_cs();
	endtask
	// cs left high afterwards so more words can be streamed
	task automatic read1(input logic [7:0] adr, output logic [15:0] r);
		host.cmd(1'b0, 1'b0, `SEP_OP_RD, adr, d);
		check({15'h0, d}, 16'h0, "dummy bit");
		host.shift16(16'h0000, r);
	endtask
	// sclk stays still while polling
	task automatic poll(input logic busy, input string msg);
		int n;
		n = 0;
		host.select(1'b0, 1'b0);
		check({15'h0, sdo_oe_n_o}, 16'h0, "output not driven");
		check({15'h0, sdo_o}, {15'h0, ~busy}, msg);
		while (sdo_o !== 1'b1 && n < 2 * PROG) begin
			@(posedge clk_i);
			n++;
		end
		check({15'h0, sdo_o}, 16'h1, "ready after program cycle");
		host.release_cs();
		check({15'h0, sdo_oe_n_o}, 16'h1, "output not released");
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		check({15'h0, sdo_oe_n_o}, 16'h1, "oe after reset");
		check({15'h0, sdo_o}, 16'h0, "sdo after reset");
		write1(8'h05, 16'h1111);
		poll(1'b0, "write taken before enable");
		$display("test reset done");
	endtask
	task automatic t_write();
		sys(1'b0, 8'hC0);
		write1(8'h05, 16'hA5C3);
		poll(1'b1, "no busy after write");
		read1(8'h05, w);
		check(w, 16'hA5C3, "single word");
		host.release_cs();
		$display("test write done");
	endtask
	task automatic t_all();
		host.cmd(1'b0, 1'b1, `SEP_OP_SYS, 8'h40, d);
		host.shift16(16'h1234, w);
		host.release_cs();
		poll(1'b1, "no busy after write all");
		write1(8'h00, 16'hBEEF);
		poll(1'b1, "no busy after write");
		read1(8'h7F, w);
		check(w, 16'h1234, "top word");
		host.shift16(16'h0000, w);
		check(w, 16'hBEEF, "wrap to zero");
		host.release_cs();
		$display("test write all done");
	endtask
	task automatic t_page();
		host.cmd(1'b0, 1'b1, `SEP_OP_PW, 8'h08, d);
		for (int i = 0; i < 4; i++) host.shift16(16'h1000 + 16'(i), w);
		host.release_cs();
		poll(1'b1, "no busy after page");
		read1(8'h08, w);
		for (int i = 0; i < 4; i++) begin
			check(w, 16'h1000 + 16'(i), "page word");
			host.shift16(16'h0000, w);
		end
		check(w, 16'h1234, "word after page");
		host.release_cs();
		$display("test page done");
	endtask
	task automatic prot_read(input string msg);
		host.cmd(1'b1, 1'b0, `SEP_OP_RD, 8'h00, d);
		host.shift16(16'h0000, w);
		host.release_cs();
		check(w, 16'h4000, msg);
	endtask
	task automatic t_prot();
		sys(1'b1, 8'hC0);
		host.cmd(1'b1, 1'b1, `SEP_OP_WR, 8'h40, d);
		host.release_cs();
		poll(1'b1, "no busy after protect write");
		write1(8'h40, 16'h5555);
		poll(1'b0, "protected word written");
		host.cmd(1'b0, 1'b1, `SEP_OP_PW, 8'h3E, d);
		for (int i = 0; i < 4; i++) host.shift16(16'h5555, w);
		host.release_cs();
		poll(1'b0, "page into protected area");
		read1(8'h3E, w);
		for (int i = 0; i < 3; i++) begin
			check(w, 16'h1234, "protected area changed");
			host.shift16(16'h0000, w);
		end
		host.release_cs();
		prot_read("protect register");
		sys(1'b1, 8'hC0);
		sys(1'b1, 8'h00);
		poll(1'b1, "no busy after lock");
		sys(1'b1, 8'hC0);
		host.cmd(1'b1, 1'b1, `SEP_OP_PW, 8'hFF, d);
		host.release_cs();
		poll(1'b0, "clear after lock");
		prot_read("protect register after lock");
		$display("test protect done");
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		t_reset();
		t_write();
		t_all();
		t_page();
		t_prot();
		end_of_test();
	end
endmodule // sep_top_bench
`default_nettype wire
